// [common/pio_pkg.sv]
// Purpose: Shared constants and types for the parallel port block
// Assumes: 32-bit register bus, each register one aligned word
// Notes:   Register indices are word indices; byte address is index * 4
package pio_pkg;

  localparam int PIO_W = 8;
  localparam int PIO_ADDR_W = 10;
  localparam int PIO_CNT_W = 16;

  // Register indices
  localparam logic [7:0] IDX_A_VAL = 8'h00;
  localparam logic [7:0] IDX_A_DIR = 8'h01;
  localparam logic [7:0] IDX_B_DIR = 8'h02;
  localparam logic [7:0] IDX_B_VAL = 8'h04;
  localparam logic [7:0] IDX_C_VAL = 8'h06;
  localparam logic [7:0] IDX_C_DIR = 8'h07;
  localparam logic [7:0] IDX_PULL = 8'h0C;
  localparam logic [7:0] IDX_PULSE_ACCUM_CONTROL = 8'h10;
  localparam logic [7:0] IDX_SHARED = 8'h11;
  localparam logic [7:0] IDX_SYSTEM_OPTIONS_TWO = 8'h38;

  // Field positions
  localparam int PULL_B_BIT = 0;
  localparam int PULL_C_BIT = 1;
  localparam int MODE_BIT = 7;
  localparam int CAP_SEL_BIT = 2;
  localparam int OPEN_DRAIN_BIT = 6;
  localparam int PA3_BIT = 3;
  localparam int PA7_BIT = 7;

  // Reset values
  localparam logic [7:0] DIR_RST = 8'h00;
  localparam logic CTL_BIT_RST = 1'b0;
  localparam logic [15:0] SHARED_RST = 16'h0000;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Pad drive pair for one 8-bit port
  typedef struct packed {
    logic [7:0] drive;
    logic [7:0] enable;
  } pio_pad_t;

  typedef enum logic [1:0] {
    WR_COLLECT = 2'b01,
    WR_RESP = 2'b10
  } pio_wr_state_t;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_RESP = 2'b10
  } pio_rd_state_t;

endpackage

// [core/pio_port_slice.sv]
// Purpose: One 8-bit bidirectional port: data latch, direction, pad drive
// Assumes: Pin inputs are synchronous to mclk
// Notes:   Pad outputs are registered after the latch, so they follow writes by two cycles
`timescale 1ns/1ps
module pio_port_slice
  import pio_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic wrValue,
  input wire logic wrDir,
  input wire logic [7:0] wdata,
  input wire logic [7:0] pinIn,
  input wire logic [7:0] altOwn,
  input wire logic [7:0] altLevel,
  input wire logic [7:0] altEn,
  input wire logic openDrain,
  output pio_pad_t pad,
  output logic [7:0] readValue,
  output logic [7:0] readDir
);

  logic [7:0] dirR;
  logic [7:0] dirNxt;
  logic [7:0] latchR;
  logic [7:0] latchNxt;
  pio_pad_t padR;
  pio_pad_t padNxt;
  logic [7:0] odMask;

  // Next state of latch, direction and pads
  always_comb begin
    dirNxt = dirR;
    latchNxt = latchR;
    if (wrDir) begin
      dirNxt = wdata;
    end
    if (wrValue) begin
      latchNxt = wdata;
    end
    odMask = {8{openDrain}};
    // Alternate owner wins; open drain drives low only
    padNxt.drive = (altOwn & altLevel) | (~altOwn & ~odMask & latchR);
    padNxt.enable = (altOwn & altEn)
      | (~altOwn & dirR & ~(odMask & latchR));
  end

  // Registers; during reset the latch follows the pins
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      dirR <= DIR_RST;
      latchR <= pinIn;
      padR <= '0;
    end else begin
      dirR <= dirNxt;
      latchR <= latchNxt;
      padR <= padNxt;
    end
  end

  // Inputs read the pin, outputs read the latch
  assign readValue = (dirR & latchR) | (~dirR & pinIn);
  assign readDir = dirR;
  assign pad = padR;

endmodule

// [core/pio_parallel_ports.sv]
// Purpose: Ports A, B and C with timer sharing and bus-mode takeover
// Assumes: AXI4-Lite slave, one write and one read in flight at most
// Notes:   Operating mode is caught while nrst is low
`timescale 1ns/1ps
module pio_parallel_ports
  import pio_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [PIO_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [PIO_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic expandedMode,
  input wire logic [7:0] portAIn,
  output pio_pad_t portAPad,
  input wire logic [7:0] portBIn,
  output pio_pad_t portBPad,
  input wire logic [7:0] portCIn,
  output pio_pad_t portCPad,
  output logic portBPullEn,
  output logic portCPullEn,
  input wire logic [7:0] addrHigh,
  input wire logic [7:0] busDataOut,
  input wire logic busDataDrive,
  output logic [7:0] busDataIn,
  input wire logic [4:0] compareOwn,
  input wire logic [4:0] compareLevel,
  input wire logic [PIO_CNT_W-1:0] timerCount,
  output logic [7:0] timerPins,
  output logic pulseAccumIn,
  output logic captureFourPulse,
  output logic [PIO_CNT_W-1:0] compareFiveValue
);

  // Bus slave state
  pio_wr_state_t wrStateR, wrStateNxt;
  pio_rd_state_t rdStateR, rdStateNxt;
  logic awHeldR, awHeldNxt, wHeldR, wHeldNxt;
  logic [7:0] wIdxR, wIdxNxt;
  logic [7:0] wDataR, wDataNxt;
  logic wLaneR, wLaneNxt;
  logic awreadyR, awreadyNxt, wreadyR, wreadyNxt;
  logic bvalidR, bvalidNxt, arreadyR, arreadyNxt, rvalidR, rvalidNxt;
  logic [1:0] brespR, brespNxt, rrespR, rrespNxt;
  logic [31:0] rdataR, rdataNxt;
  logic doWrite;

  // Control and timer-side state
  logic modeExpR;
  logic pullBR, pullBNxt, pullCR, pullCNxt;
  logic capSelR, capSelNxt, openDrainR, openDrainNxt;
  logic [PIO_CNT_W-1:0] sharedR, sharedNxt;
  logic pin3PrevR, capPulseR, capPulseNxt;
  logic pullBOutR, pullCOutR, pulseR;
  logic [7:0] timerPinsR, busInR;

  // Port strobes and alternate ownership
  logic wrAVal, wrADir, wrBVal, wrBDir, wrCVal, wrCDir;
  logic [7:0] aOwn, aLevel, bOwn, cOwn, cEn;
  logic [7:0] aRd, aDir, bRd, bDir, cRd, cDir;

  // Mapped-index check; B and C data leave the map in bus modes
  function automatic logic idxMapped(input logic [7:0] idx, input logic exp);
    logic ok;
    ok = 1'b0;
    case (idx)
      IDX_A_VAL, IDX_A_DIR, IDX_B_DIR, IDX_C_DIR: ok = 1'b1;
      IDX_PULL, IDX_PULSE_ACCUM_CONTROL, IDX_SHARED, IDX_SYSTEM_OPTIONS_TWO: ok = 1'b1;
      IDX_B_VAL, IDX_C_VAL: ok = !exp;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // Write channel: take address and data in any order, then respond
  always_comb begin
    wrStateNxt = wrStateR;
    awHeldNxt = awHeldR;
    wHeldNxt = wHeldR;
    wIdxNxt = wIdxR;
    wDataNxt = wDataR;
    wLaneNxt = wLaneR;
    bvalidNxt = bvalidR;
    brespNxt = brespR;
    doWrite = 1'b0;
    case (wrStateR)
      WR_COLLECT: begin
        if (s_axi_awvalid && awreadyR) begin
          awHeldNxt = 1'b1;
          wIdxNxt = s_axi_awaddr[PIO_ADDR_W-1:2];
        end
        if (s_axi_wvalid && wreadyR) begin
          wHeldNxt = 1'b1;
          wDataNxt = s_axi_wdata[7:0];
          wLaneNxt = s_axi_wstrb[0];
        end
        if (awHeldR && wHeldR) begin
          doWrite = idxMapped(wIdxR, modeExpR) && wLaneR;
          brespNxt = idxMapped(wIdxR, modeExpR) ? RESP_OKAY : RESP_SLVERR;
          bvalidNxt = 1'b1;
          awHeldNxt = 1'b0;
          wHeldNxt = 1'b0;
          wrStateNxt = WR_RESP;
        end
      end
      WR_RESP: begin
        if (s_axi_bready) begin
          bvalidNxt = 1'b0;
          wrStateNxt = WR_COLLECT;
        end
      end
      default: wrStateNxt = WR_COLLECT;
    endcase
    awreadyNxt = (wrStateNxt == WR_COLLECT) && !awHeldNxt;
    wreadyNxt = (wrStateNxt == WR_COLLECT) && !wHeldNxt;
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      wrStateR <= WR_COLLECT;
      awHeldR <= 1'b0;
      wHeldR <= 1'b0;
      wIdxR <= 8'h00;
      wDataR <= 8'h00;
      wLaneR <= 1'b0;
      awreadyR <= 1'b0;
      wreadyR <= 1'b0;
      bvalidR <= 1'b0;
      brespR <= RESP_OKAY;
    end else begin
      wrStateR <= wrStateNxt;
      awHeldR <= awHeldNxt;
      wHeldR <= wHeldNxt;
      wIdxR <= wIdxNxt;
      wDataR <= wDataNxt;
      wLaneR <= wLaneNxt;
      awreadyR <= awreadyNxt;
      wreadyR <= wreadyNxt;
      bvalidR <= bvalidNxt;
      brespR <= brespNxt;
    end
  end

  // Read channel: answer one cycle after the address is taken
  always_comb begin
    rdStateNxt = rdStateR;
    rvalidNxt = rvalidR;
    rdataNxt = rdataR;
    rrespNxt = rrespR;
    case (rdStateR)
      RD_IDLE: begin
        if (s_axi_arvalid && arreadyR) begin
          rdataNxt = 32'h0000_0000;
          rrespNxt = RESP_OKAY;
          rvalidNxt = 1'b1;
          rdStateNxt = RD_RESP;
          case (s_axi_araddr[PIO_ADDR_W-1:2])
            IDX_A_VAL: rdataNxt[7:0] = aRd;
            IDX_A_DIR: rdataNxt[7:0] = aDir;
            IDX_B_DIR: rdataNxt[7:0] = bDir;
            IDX_C_DIR: rdataNxt[7:0] = cDir;
            IDX_B_VAL: rdataNxt[7:0] = bRd;
            IDX_C_VAL: rdataNxt[7:0] = cRd;
            IDX_PULL: begin
              rdataNxt[PULL_B_BIT] = pullBR;
              rdataNxt[PULL_C_BIT] = pullCR;
              rdataNxt[MODE_BIT] = modeExpR;
            end
            IDX_PULSE_ACCUM_CONTROL: rdataNxt[CAP_SEL_BIT] = capSelR;
            IDX_SHARED: rdataNxt[PIO_CNT_W-1:0] = sharedR;
            IDX_SYSTEM_OPTIONS_TWO: rdataNxt[OPEN_DRAIN_BIT] = openDrainR;
            default: rdataNxt = 32'h0000_0000;
          endcase
          if (!idxMapped(s_axi_araddr[PIO_ADDR_W-1:2], modeExpR)) begin
            rdataNxt = 32'h0000_0000;
            rrespNxt = RESP_SLVERR;
          end
        end
      end
      RD_RESP: begin
        if (s_axi_rready) begin
          rvalidNxt = 1'b0;
          rdStateNxt = RD_IDLE;
        end
      end
      default: rdStateNxt = RD_IDLE;
    endcase
    arreadyNxt = (rdStateNxt == RD_IDLE);
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rdStateR <= RD_IDLE;
      rvalidR <= 1'b0;
      rdataR <= 32'h0000_0000;
      rrespR <= RESP_OKAY;
      arreadyR <= 1'b0;
    end else begin
      rdStateR <= rdStateNxt;
      rvalidR <= rvalidNxt;
      rdataR <= rdataNxt;
      rrespR <= rrespNxt;
      arreadyR <= arreadyNxt;
    end
  end

  // Register write strobes
  assign wrAVal = doWrite && (wIdxR == IDX_A_VAL);
  assign wrADir = doWrite && (wIdxR == IDX_A_DIR);
  assign wrBVal = doWrite && (wIdxR == IDX_B_VAL);
  assign wrBDir = doWrite && (wIdxR == IDX_B_DIR);
  assign wrCVal = doWrite && (wIdxR == IDX_C_VAL);
  assign wrCDir = doWrite && (wIdxR == IDX_C_DIR);

  // Control bits, shared capture/compare register and capture edge
  always_comb begin
    pullBNxt = pullBR;
    pullCNxt = pullCR;
    capSelNxt = capSelR;
    openDrainNxt = openDrainR;
    sharedNxt = sharedR;
    capPulseNxt = 1'b0;
    if (doWrite && (wIdxR == IDX_PULL)) begin
      pullBNxt = wDataR[PULL_B_BIT];
      pullCNxt = wDataR[PULL_C_BIT];
    end
    if (doWrite && (wIdxR == IDX_PULSE_ACCUM_CONTROL)) begin
      capSelNxt = wDataR[CAP_SEL_BIT];
    end
    if (doWrite && (wIdxR == IDX_SYSTEM_OPTIONS_TWO)) begin
      openDrainNxt = wDataR[OPEN_DRAIN_BIT];
    end
    if (capSelR) begin
      // Any line three edge captures, including ones made by own writes
      if (portAIn[PA3_BIT] != pin3PrevR) begin
        sharedNxt = timerCount;
        capPulseNxt = 1'b1;
      end
    end else if (doWrite && (wIdxR == IDX_SHARED)) begin
      sharedNxt = {8'h00, wDataR};
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      modeExpR <= expandedMode;
      pullBR <= CTL_BIT_RST;
      pullCR <= CTL_BIT_RST;
      capSelR <= CTL_BIT_RST;
      openDrainR <= CTL_BIT_RST;
      sharedR <= SHARED_RST;
      capPulseR <= 1'b0;
      pin3PrevR <= portAIn[PA3_BIT];
      pullBOutR <= 1'b0;
      pullCOutR <= 1'b0;
      pulseR <= 1'b0;
      timerPinsR <= 8'h00;
      busInR <= 8'h00;
    end else begin
      pullBR <= pullBNxt;
      pullCR <= pullCNxt;
      capSelR <= capSelNxt;
      openDrainR <= openDrainNxt;
      sharedR <= sharedNxt;
      capPulseR <= capPulseNxt;
      pin3PrevR <= portAIn[PA3_BIT];
      pullBOutR <= pullBNxt && !modeExpR;
      pullCOutR <= pullCNxt && !modeExpR;
      pulseR <= portAIn[PA7_BIT];
      timerPinsR <= portAIn;
      busInR <= portCIn;
    end
  end

  // Port A: compare ownership of lines 7..3; line 3 freed when capturing
  assign aOwn = {compareOwn[4:1], compareOwn[0] && !capSelR, 3'b000};
  assign aLevel = {compareLevel, 3'b000};
  // Port B drives address in bus modes; port C follows bus direction
  assign bOwn = {8{modeExpR}};
  assign cOwn = {8{modeExpR}};
  assign cEn = {8{busDataDrive}};

  pio_port_slice port_a_value (
    .mclk(mclk),
    .nrst(nrst),
    .wrValue(wrAVal),
    .wrDir(wrADir),
    .wdata(wDataR),
    .pinIn(portAIn),
    .altOwn(aOwn),
    .altLevel(aLevel),
    .altEn(aOwn),
    .openDrain(1'b0),
    .pad(portAPad),
    .readValue(aRd),
    .readDir(aDir)
  );

  pio_port_slice port_b_value (
    .mclk(mclk),
    .nrst(nrst),
    .wrValue(wrBVal),
    .wrDir(wrBDir),
    .wdata(wDataR),
    .pinIn(portBIn),
    .altOwn(bOwn),
    .altLevel(addrHigh),
    .altEn(bOwn),
    .openDrain(1'b0),
    .pad(portBPad),
    .readValue(bRd),
    .readDir(bDir)
  );

  pio_port_slice port_c_value (
    .mclk(mclk),
    .nrst(nrst),
    .wrValue(wrCVal),
    .wrDir(wrCDir),
    .wdata(wDataR),
    .pinIn(portCIn),
    .altOwn(cOwn),
    .altLevel(busDataOut),
    .altEn(cEn),
    .openDrain(openDrainR),
    .pad(portCPad),
    .readValue(cRd),
    .readDir(cDir)
  );

  // Outputs straight from flops
  assign s_axi_awready = awreadyR;
  assign s_axi_wready = wreadyR;
  assign s_axi_bvalid = bvalidR;
  assign s_axi_bresp = brespR;
  assign s_axi_arready = arreadyR;
  assign s_axi_rvalid = rvalidR;
  assign s_axi_rdata = rdataR;
  assign s_axi_rresp = rrespR;
  assign portBPullEn = pullBOutR;
  assign portCPullEn = pullCOutR;
  assign busDataIn = busInR;
  assign timerPins = timerPinsR;
  assign pulseAccumIn = pulseR;
  assign captureFourPulse = capPulseR;
  assign compareFiveValue = sharedR;

endmodule

// [testbench/pio_parallel_ports_sva.sv]
// Purpose: Port-level assertions for the parallel port block
// Assumes: Bound to pio_parallel_ports, one clock domain
// Notes:   Pads and timer feeds are registered copies of their causes
`timescale 1ns/1ps
module pio_parallel_ports_chk
  import pio_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic expandedMode,
  input wire logic [7:0] portAIn,
  input wire pio_pad_t portAPad,
  input wire pio_pad_t portBPad,
  input wire logic [7:0] portCIn,
  input wire pio_pad_t portCPad,
  input wire logic portBPullEn,
  input wire logic portCPullEn,
  input wire logic [7:0] addrHigh,
  input wire logic [7:0] busDataOut,
  input wire logic busDataDrive,
  input wire logic [7:0] busDataIn,
  input wire logic [4:0] compareOwn,
  input wire logic [4:0] compareLevel,
  input wire logic pulseAccumIn,
  input wire logic captureFourPulse
);
  // One clock; reset switches every check off
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // Timer paths to and from port A, and port A and C pins released right after reset
  accum_follow_a:
    assert property ($past(nrst) |-> pulseAccumIn == $past(portAIn[7]))
    else $error("accumulator input not the line seven pin");
  capture_edge_a:
    assert property (captureFourPulse |->
      $past(portAIn[3]) != $past(portAIn[3], 2))
    else $error("capture pulse without a line three edge");
  compare_seven_a:
    assert property ($past(nrst) && $past(compareOwn[4]) |->
      portAPad.drive[7] == $past(compareLevel[4]))
    else $error("line seven ignores its compare level");
  reset_inputs_a:
    assert property ($rose(nrst) |->
      portAPad.enable == 8'h00 && portCPad.enable == 8'h00)
    else $error("pin driven right after reset");
  // Bus takeover in expanded mode
  addr_high_a:
    assert property (expandedMode && $past(nrst) |->
      portBPad == {$past(addrHigh), 8'hFF})
    else $error("port B not the high address");
  pull_off_a:
    assert property (expandedMode |-> !portBPullEn && !portCPullEn)
    else $error("pull-up on in expanded mode");
  data_bus_a:
    assert property (expandedMode && $past(nrst) |->
      portCPad.enable == {8{$past(busDataDrive)}} &&
      (!$past(busDataDrive) || portCPad.drive == $past(busDataOut)))
    else $error("port C not the data bus");
  data_in_a:
    assert property ($past(nrst) |-> busDataIn == $past(portCIn))
    else $error("bus data input not the port C pins");
  // Main scenarios reached
  cover property (captureFourPulse);
  cover property (expandedMode && busDataDrive);
  cover property (portCPad.enable == 8'hF0);
endmodule

bind pio_parallel_ports pio_parallel_ports_chk i_chk (
  .mclk, .nrst, .expandedMode, .portAIn, .portAPad, .portBPad, .portCIn,
  .portCPad, .portBPullEn, .portCPullEn, .addrHigh, .busDataOut,
  .busDataDrive, .busDataIn, .compareOwn, .compareLevel, .pulseAccumIn,
  .captureFourPulse
);

// [testbench/pio_pin_model.sv]
// Purpose: Pins and outside devices seen by the parallel ports
// Assumes: Outside drivers act only where the pad is released
// Notes:   Floating lines toggle every cycle to expose stale reads
`timescale 1ns/1ps
module pio_pin_model
  import pio_pkg::*;
(
  input wire logic mclk,
  input wire pio_pad_t padA,
  input wire pio_pad_t padB,
  input wire pio_pad_t padC,
  input wire logic pullB,
  input wire logic pullC,
  input wire logic [7:0] extA,
  input wire logic [7:0] extC,
  input wire logic extCEn,
  output logic [7:0] pinA,
  output logic [7:0] pinB,
  output logic [7:0] pinC
);
  logic pat = 1'h0;
  // Level of a released line with no pull and no outside driver
  always @(posedge mclk) begin
    pat <= ~pat;
  end
  // Driven bits follow the pad, released bits the outside level
  function automatic logic [7:0] lvl(pio_pad_t p, logic [7:0] o);
    return (p.enable & p.drive) | (~p.enable & o);
  endfunction
  assign pinA = lvl(padA, extA);
  assign pinB = lvl(padB, pullB ? 8'hFF : {8{pat}});
  assign pinC = lvl(padC, extCEn ? extC : pullC ? 8'hFF : {8{pat}});
endmodule

// [testbench/pio_parallel_ports_test.sv]
// Purpose: Self-checking bench for the parallel port block
// Assumes: Pins resolved by pio_pin_model, one 20 MHz clock
// Notes:   Registers reached as an AXI4-Lite master
`timescale 1ns/1ps
module pio_parallel_ports_test
  import pio_pkg::*;
;
  localparam logic W = 1'h1;
  localparam logic R = 1'h0;
  localparam logic [1:0] OK = RESP_OKAY;
  localparam logic [1:0] ERR = RESP_SLVERR;
  logic mclk = 1'h0, nrst = 1'h0, expandedMode = 1'h0;
  logic [PIO_ADDR_W-1:0] s_axi_awaddr = 10'h0, s_axi_araddr = 10'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [7:0] timerPins;
  logic [15:0] compareFiveValue;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, busDataDrive = 1'h0;
  logic [7:0] addrHigh = 8'h00, busDataOut = 8'h00;
  logic [4:0] compareOwn = 5'h00, compareLevel = 5'h00;
  logic [15:0] timerCount = 16'h0000;
  logic [7:0] extA = 8'h52, extC = 8'h3C;
  logic extCEn = 1'h1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, portBPullEn, portCPullEn, pulseAccumIn;
  logic captureFourPulse;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [7:0] portAIn, portBIn, portCIn, busDataIn;
  pio_pad_t portAPad, portBPad, portCPad;
  int error_cnt = 0;
  int checks = 0;

  pio_parallel_ports i_dut (
    .mclk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .expandedMode, .portAIn, .portAPad,
    .portBIn, .portBPad, .portCIn, .portCPad, .portBPullEn, .portCPullEn,
    .addrHigh, .busDataOut, .busDataDrive, .busDataIn, .compareOwn,
    .compareLevel, .timerCount, .timerPins, .pulseAccumIn,
    .captureFourPulse, .compareFiveValue
  );
  pio_pin_model i_pins (
    .mclk, .padA(portAPad), .padB(portBPad), .padC(portCPad),
    .pullB(portBPullEn), .pullC(portCPullEn), .extA, .extC, .extCEn,
    .pinA(portAIn), .pinB(portBIn), .pinC(portCIn)
  );

  // Clock at 50 ns
  initial begin
    forever #25 mclk = ~mclk;
  end
  // Compare and count
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One bus write or read, held until each channel is taken
  task automatic xfer(logic w, logic [7:0] i, logic [31:0] d, logic [1:0] e);
    int n;
    n = 0;
    if (w) begin
      s_axi_awaddr <= {i, 2'h0};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
    end else begin
      s_axi_araddr <= {i, 2'h0};
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
    end
    do begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      n++;
    end while (!(w ? s_axi_bvalid : s_axi_rvalid) && n < 50);
    s_axi_bready <= 1'h0;
    s_axi_rready <= 1'h0;
    chk("answer", 32'h1, 32'(w ? s_axi_bvalid : s_axi_rvalid));
    chk("resp", 32'(e), 32'(w ? s_axi_bresp : s_axi_rresp));
    if (!w) chk("rdata", d, s_axi_rdata);
    // Let one edge pass so the next call does not re-raise at once
    @(posedge mclk);
  endtask
  // Let registered pads follow
  task automatic settle;
    repeat (3) @(posedge mclk);
    #1;
  endtask
  // Reset for 8 cycles in the given mode
  task automatic rst(logic m);
    @(posedge mclk);
    nrst <= 1'h0;
    expandedMode <= m;
    repeat (8) @(posedge mclk);
    nrst <= 1'h1;
    @(posedge mclk);
  endtask
  // Reset state and unmapped places
  task automatic t_reset;
    xfer(R, IDX_A_DIR, 32'h0, OK);
    xfer(R, IDX_B_DIR, 32'h0, OK);
    xfer(R, IDX_C_DIR, 32'h0, OK);
    xfer(R, IDX_PULSE_ACCUM_CONTROL, 32'h0, OK);
    xfer(R, IDX_A_VAL, 32'h52, OK);
    chk("padAEn", 32'h0, 32'(portAPad.enable));
    s_axi_wstrb <= 4'hE;
    xfer(W, IDX_A_DIR, 32'hFF, OK);
    s_axi_wstrb <= 4'hF;
    xfer(R, IDX_A_DIR, 32'h0, OK);
    xfer(R, 8'h3F, 32'h0, ERR);
    xfer(W, 8'h3F, 32'h11, ERR);
  endtask
  // Port A directions and compare sharing
  task automatic t_port_a;
    compareOwn <= 5'h01;
    compareLevel <= 5'h01;
    settle();
    chk("oc5", 32'h1, 32'(portAPad.drive[3]));
    compareOwn <= 5'h00;
    xfer(W, IDX_A_DIR, 32'h88, OK);
    xfer(W, IDX_A_VAL, 32'h80, OK);
    settle();
    chk("padAEn", 32'h88, 32'(portAPad.enable));
    chk("padADrv", 32'h80, 32'(portAPad.drive & 8'h88));
    chk("accum", 32'h1, 32'(pulseAccumIn));
    chk("tpins", 32'hD2, 32'(timerPins));
    xfer(R, IDX_A_VAL, 32'hD2, OK);
    compareOwn <= 5'h10;
    compareLevel <= 5'h00;
    settle();
    chk("line7", 32'h0, 32'(portAPad.drive[7]));
    compareOwn <= 5'h00;
  endtask
  // Written line three edge captured, shared register then locked
  task automatic t_capture;
    int n;
    n = 0;
    timerCount <= 16'h1234;
    xfer(W, IDX_PULSE_ACCUM_CONTROL, 32'h04, OK);
    xfer(R, IDX_PULSE_ACCUM_CONTROL, 32'h04, OK);
    xfer(W, IDX_A_VAL, 32'h88, OK);
    while (captureFourPulse !== 1'h1 && n < 10) begin
      @(posedge mclk);
      n++;
    end
    chk("capture", 32'h1, 32'(captureFourPulse));
    xfer(R, IDX_SHARED, 32'h1234, OK);
    xfer(W, IDX_SHARED, 32'h55, OK);
    xfer(R, IDX_SHARED, 32'h1234, OK);
    chk("cmp5", 32'h1234, 32'(compareFiveValue));
    xfer(W, IDX_PULSE_ACCUM_CONTROL, 32'h00, OK);
    xfer(W, IDX_SHARED, 32'h77, OK);
    xfer(R, IDX_SHARED, 32'h77, OK);
  endtask
  // Pull-ups on ports B and C, reset latch and open drain on port C
  task automatic t_ports_bc;
    xfer(W, IDX_PULL, 32'h03, OK);
    xfer(R, IDX_PULL, 32'h03, OK);
    chk("pullB", 32'h1, 32'(portBPullEn));
    chk("pullC", 32'h1, 32'(portCPullEn));
    xfer(R, IDX_B_VAL, 32'hFF, OK);
    xfer(W, IDX_C_DIR, 32'hFF, OK);
    settle();
    chk("padC", 32'h3CFF, 32'(portCPad));
    xfer(W, IDX_SYSTEM_OPTIONS_TWO, 32'h40, OK);
    xfer(W, IDX_C_VAL, 32'h0F, OK);
    settle();
    chk("odEn", 32'hF0, 32'(portCPad.enable));
    chk("odDrv", 32'h00, 32'(portCPad.drive & 8'hF0));
    xfer(W, IDX_SYSTEM_OPTIONS_TWO, 32'h00, OK);
    settle();
    chk("padC", 32'h0FFF, 32'(portCPad));
  endtask
  // Expanded mode bus takeover
  task automatic t_expanded;
    addrHigh <= 8'hA5;
    busDataOut <= 8'hC3;
    busDataDrive <= 1'h1;
    rst(1'h1);
    settle();
    chk("padB", 32'hA5FF, 32'(portBPad));
    chk("padC", 32'hC3FF, 32'(portCPad));
    busDataDrive <= 1'h0;
    settle();
    chk("busIn", 32'h3C, 32'(busDataIn));
    xfer(W, IDX_B_VAL, 32'h12, ERR);
    xfer(R, IDX_C_VAL, 32'h0, ERR);
    xfer(R, IDX_B_DIR, 32'h0, OK);
  endtask
  // Verdict and end of run
  task automatic print_verdict;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    rst(1'h0);
    t_reset();
    t_port_a();
    t_capture();
    t_ports_bc();
    t_expanded();
    print_verdict();
  end
  // Watchdog against a hang
  initial begin
    repeat (5000) @(posedge mclk);
    error_cnt++;
    print_verdict();
  end
endmodule
